// [dfw_diag.sv]
// Diagnostics fault latches, loopback steering and windowed watchdog.
// Functional notes
// - Supply rail faults latch in sixteen flags.
// - Supply flags clear on writing one.
// - System reset clears all fault flags.
// - Channel one/two overvoltage latches own flag.
// - Front-end flags clear on writing zero.
// - Each third-channel input has overvoltage flag.
// - Config bits switch third-channel pull-up diagnostic.
// - Gain output over threshold latches flag.
// - Sensor loopback routes generator to amplifiers.
// - Converter loopback needs three bits set.
// - Converter loopback muxes buffer, stops analog polling.
// - Digital polling continues during converter loopback.
// - Converter output stays driven in loopback.
// - Writing enable bit starts the watchdog.
// - Lower trigger holds window opening time.
// - Timeout equals trigger plus one times 2 ms.
// - Missing service resets the processor.
// - Early service resets the processor.
// - Watchdog reset keeps watchdog enabled.
// - Watchdog reset flag set, cleared by one.
// - Early flag records early-service cause.
// - Processor reset zeroes output, floats pins.
`timescale 1ns/100ps
module dfw_diag #(
    parameter int TICK_CYCLES = dfw_pkg::TICK_CYCLES,
    parameter int GPIO_W = 8
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic AVS_HIGH_WIN_I,
    input wire logic [15:0] SUPPLY_FAULT_I,
    input wire logic [3:0] FE_OV12_I,
    input wire logic [1:0] FE_OV3_I,
    input wire logic [2:0] FE_OUT_OVER_I,
    input wire logic [GPIO_W-1:0] GPIO_OUT_I,
    input wire logic [GPIO_W-1:0] GPIO_OE_I,
    output logic [15:0] FE_DIAG_CFG_A_O,
    output logic [15:0] FE_DIAG_CFG_B_O,
    output logic SENSOR_LB_O,
    output logic CONV_LB_O,
    output logic ANALOG_POLL_EN_O,
    output logic DIGITAL_POLL_EN_O,
    output logic CONV_OUT_DRIVE_O,
    output logic CONV_OUT_ZERO_O,
    output logic PROC_RST_O,
    output logic [GPIO_W-1:0] GPIO_OUT_O,
    output logic [GPIO_W-1:0] GPIO_OE_O
);
    // Fault inputs come from analog comparators, so they pass a two-stage synchroniser.
    logic [24:0] raw_s1_ff;
    logic [24:0] raw_s2_ff;
    wire [24:0] raw_in = {FE_OUT_OVER_I, FE_OV3_I, FE_OV12_I, SUPPLY_FAULT_I};
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            raw_s1_ff <= '0;
            raw_s2_ff <= '0;
        end else begin
            raw_s1_ff <= raw_in;
            raw_s2_ff <= raw_s1_ff;
        end
    end
    wire [15:0] supply_evt = raw_s2_ff[15:0];
    wire [8:0] fe_evt = raw_s2_ff[24:16];

    // Bus decode: one-cycle wait on reads only, so read data come from a flop.
    logic rd_done_ff;
    wire [5:0] full_addr = {AVS_HIGH_WIN_I, AVS_ADDRESS_I};
    wire wr_acc = AVS_WRITE_I;
    wire be_ok = AVS_BYTEENABLE_I[0];
    wire wr_supply_a = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_SUPPLY_A};
    wire wr_supply_b = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_SUPPLY_B};
    wire wr_fe = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_FE_FLAGS};
    wire wr_cfg_a = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_FE_CFG_A};
    wire wr_cfg_b = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_FE_CFG_B};
    wire wr_sens = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_SENS_LB};
    wire wr_conv = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_CONV_LB};
    wire wr_wd = wr_acc && be_ok && full_addr == {1'b0, dfw_pkg::ADDR_WD_CTRL};
    wire wr_high = wr_acc && be_ok && full_addr == dfw_pkg::ADDR_WD_HIGH;
    wire wr_low = wr_acc && be_ok && full_addr == dfw_pkg::ADDR_WD_LOW;
    assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_done_ff;

    // Registers that a watchdog reset returns to defaults use a combined reset.
    logic proc_rst_ff;
    logic [15:0] supply_a_ff;
    logic [15:0] supply_b_ff;
    logic [8:0] fe_flags_ff;
    logic [15:0] cfg_a_ff;
    logic [15:0] cfg_b_ff;
    logic sens_lb_ff;
    logic [2:0] conv_lb_ff;

    // Set wins over clear: a fault arriving with the clear write stays latched.
    wire [15:0] clr_a = wr_supply_a ? AVS_WRITEDATA_I[15:0] : 16'h0000;
    wire [15:0] clr_b = wr_supply_b ? AVS_WRITEDATA_I[15:0] : 16'h0000;
    wire [15:0] nxt_supply_a = {8'h00, (supply_a_ff[7:0] & ~clr_a[7:0]) | supply_evt[7:0]};
    wire [15:0] nxt_supply_b = {8'h00, (supply_b_ff[7:0] & ~clr_b[7:0]) | supply_evt[15:8]};
    wire [8:0] fe_keep = wr_fe ? AVS_WRITEDATA_I[8:0] : 9'h1FF;
    wire [8:0] nxt_fe_flags = (fe_flags_ff & fe_keep) | fe_evt;

    // Flag and control registers; system reset and watchdog reset both clear them.
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            supply_a_ff <= dfw_pkg::SUPPLY_RST;
            supply_b_ff <= dfw_pkg::SUPPLY_RST;
            fe_flags_ff <= dfw_pkg::FE_RST;
            cfg_a_ff <= 16'h0000;
            cfg_b_ff <= 16'h0000;
            sens_lb_ff <= 1'b0;
            conv_lb_ff <= 3'h0;
        end else if (proc_rst_ff) begin
            supply_a_ff <= dfw_pkg::SUPPLY_RST;
            supply_b_ff <= dfw_pkg::SUPPLY_RST;
            fe_flags_ff <= dfw_pkg::FE_RST;
            cfg_a_ff <= 16'h0000;
            cfg_b_ff <= 16'h0000;
            sens_lb_ff <= 1'b0;
            conv_lb_ff <= 3'h0;
        end else begin
            supply_a_ff <= nxt_supply_a;
            supply_b_ff <= nxt_supply_b;
            fe_flags_ff <= nxt_fe_flags;
            if (wr_cfg_a) cfg_a_ff <= AVS_WRITEDATA_I[15:0];
            if (wr_cfg_b) cfg_b_ff <= AVS_WRITEDATA_I[15:0];
            if (wr_sens) sens_lb_ff <= AVS_WRITEDATA_I[dfw_pkg::SENS_LB_EN_BIT];
            if (wr_conv) conv_lb_ff <= AVS_WRITEDATA_I[2:0];
        end
    end

    // Loopback steering to the analog signal chain.
    wire conv_lb_active = conv_lb_ff[dfw_pkg::CONV_CONNECT_BIT]
        && conv_lb_ff[dfw_pkg::CONV_AMP_EN_BIT]
        && conv_lb_ff[dfw_pkg::CONV_LB_EN_BIT];
    assign SENSOR_LB_O = sens_lb_ff;
    assign CONV_LB_O = conv_lb_active;
    assign ANALOG_POLL_EN_O = !conv_lb_active;
    assign DIGITAL_POLL_EN_O = 1'b1;
    // The converter stays driven in every mode except while the processor is held.
    assign CONV_OUT_DRIVE_O = !proc_rst_ff;
    assign FE_DIAG_CFG_A_O = cfg_a_ff;
    assign FE_DIAG_CFG_B_O = cfg_b_ff;

    // Watchdog state survives its own reset of the processor; only system reset clears it.
    typedef enum logic [1:0] {WD_OFF, WD_RUN} dfw_wd_state_t;
    dfw_wd_state_t wd_state_ff;
    logic [7:0] trig_high_ff;
    logic [7:0] trig_low_ff;
    logic [$clog2(TICK_CYCLES)-1:0] div_ff;
    logic [8:0] ticks_ff;
    logic wd_rst_flag_ff;
    logic early_flag_ff;
    logic [4:0] rst_cnt_ff;

    // Tick divider yields one pulse every 2 ms of core clock.
    wire restart = (wd_state_ff == WD_OFF && wr_wd && AVS_WRITEDATA_I[dfw_pkg::WD_EN_BIT])
        || (wd_state_ff == WD_RUN && wr_high && !proc_rst_ff);
    wire tick = div_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
    // Timeout (trigger + 1) * 2 ms: compare elapsed ticks to trigger + 1.
    wire [8:0] low_lim = {1'b0, trig_low_ff} + 9'h001;
    wire [8:0] high_lim = {1'b0, trig_high_ff} + 9'h001;
    wire late_fire = wd_state_ff == WD_RUN && !proc_rst_ff && ticks_ff >= high_lim;
    wire early_fire = wd_state_ff == WD_RUN && !proc_rst_ff && wr_high
        && ticks_ff < low_lim;
    wire fire = late_fire || early_fire;
    wire flag_clr = wr_wd && AVS_WRITEDATA_I[dfw_pkg::WD_RST_FLAG_BIT];

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_ff <= '0;
            ticks_ff <= 9'h000;
        end else if (restart || fire) begin
            div_ff <= '0;
            ticks_ff <= 9'h000;
        end else if (tick) begin
            div_ff <= '0;
            ticks_ff <= (ticks_ff == 9'h1FF) ? ticks_ff : ticks_ff + 9'h001;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // Enable, triggers and cause flags.
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wd_state_ff <= WD_OFF;
            trig_high_ff <= dfw_pkg::TRIG_RST;
            trig_low_ff <= 8'h00;
            wd_rst_flag_ff <= 1'b0;
            early_flag_ff <= 1'b0;
        end else begin
            if (wr_wd && AVS_WRITEDATA_I[dfw_pkg::WD_EN_BIT]) wd_state_ff <= WD_RUN;
            if (wr_high && !proc_rst_ff) trig_high_ff <= AVS_WRITEDATA_I[7:0];
            if (wr_low && !proc_rst_ff) trig_low_ff <= AVS_WRITEDATA_I[7:0];
            if (fire) begin
                wd_rst_flag_ff <= 1'b1;
                early_flag_ff <= early_fire;
            end else if (flag_clr) begin
                wd_rst_flag_ff <= 1'b0;
            end
        end
    end

    // Processor reset pulse of fixed length after any watchdog event.
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_cnt_ff <= 5'h00;
            proc_rst_ff <= 1'b0;
        end else if (fire) begin
            rst_cnt_ff <= 5'(dfw_pkg::PROC_RST_CYCLES);
            proc_rst_ff <= 1'b1;
        end else if (rst_cnt_ff != 5'h00) begin
            rst_cnt_ff <= rst_cnt_ff - 5'h01;
            proc_rst_ff <= rst_cnt_ff != 5'h01;
        end
    end
    assign PROC_RST_O = proc_rst_ff;
    // During processor reset the output goes to 0 V and every pin floats.
    assign CONV_OUT_ZERO_O = proc_rst_ff || !RST_B_I;
    assign GPIO_OE_O = proc_rst_ff ? '0 : GPIO_OE_I;
    assign GPIO_OUT_O = proc_rst_ff ? '0 : GPIO_OUT_I;

    // Read mux; unmapped addresses read zero.
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (full_addr)
            {1'b0, dfw_pkg::ADDR_SUPPLY_A}: rdata = {16'h0000, supply_a_ff};
            {1'b0, dfw_pkg::ADDR_SUPPLY_B}: rdata = {16'h0000, supply_b_ff};
            {1'b0, dfw_pkg::ADDR_FE_FLAGS}: rdata = {23'h0, fe_flags_ff};
            {1'b0, dfw_pkg::ADDR_FE_CFG_A}: rdata = {16'h0000, cfg_a_ff};
            {1'b0, dfw_pkg::ADDR_FE_CFG_B}: rdata = {16'h0000, cfg_b_ff};
            {1'b0, dfw_pkg::ADDR_SENS_LB}: rdata = {31'h0, sens_lb_ff};
            {1'b0, dfw_pkg::ADDR_CONV_LB}: rdata = {29'h0, conv_lb_ff};
            {1'b0, dfw_pkg::ADDR_WD_CTRL}: rdata = {29'h0, early_flag_ff, wd_rst_flag_ff,
                wd_state_ff == WD_RUN};
            dfw_pkg::ADDR_WD_HIGH: rdata = {24'h0, trig_high_ff};
            dfw_pkg::ADDR_WD_LOW: rdata = {24'h0, trig_low_ff};
            default: rdata = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rd_done_ff <= 1'b0;
            AVS_READDATA_O <= 32'h0000_0000;
        end else begin
            rd_done_ff <= AVS_READ_I && !rd_done_ff;
            if (AVS_READ_I && !rd_done_ff) AVS_READDATA_O <= rdata;
        end
    end

    // Checks next to the logic they guard.
    a_supply_latch: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        supply_evt[0] && !proc_rst_ff |=> supply_a_ff[0]) else $error("supply flag lost");
    a_supply_w1c: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        !wr_supply_a && !proc_rst_ff |=> supply_a_ff[0] >= $past(supply_a_ff[0]))
        else $error("supply flag cleared without write");
    a_fe_w0c: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        wr_fe && !AVS_WRITEDATA_I[0] && !fe_evt[0] && !proc_rst_ff |=> !fe_flags_ff[0])
        else $error("front-end flag not cleared");
    a_conv_lb: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        CONV_LB_O == (conv_lb_ff == 3'h7)) else $error("converter loopback decode");
    a_late_reset: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        late_fire |=> PROC_RST_O [*8]) else $error("late reset too short");
    a_early_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        early_fire |=> early_flag_ff && wd_rst_flag_ff) else $error("early cause missing");
    a_wd_stays_on: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        fire |-> ##[1:20] (wd_state_ff == WD_RUN && !proc_rst_ff)) else $error("wd lost");
    a_pins_float: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        proc_rst_ff |-> GPIO_OE_O == '0 && CONV_OUT_ZERO_O) else $error("pins driven in reset");
    c_late: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I) late_fire);
    c_early: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I) early_fire);
    c_conv_lb: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I) conv_lb_active);
    c_service: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        restart && wd_state_ff == WD_RUN && !fire);
    c_flag_clear: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I) flag_clr);

    // Cycles since the window opened, kept only to cross-check the tick arithmetic.
    // It saturates rather than wraps, so a long idle spell cannot fake a match.
    logic [31:0] win_cyc_ff;
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            win_cyc_ff <= 32'h0000_0000;
        end else if (restart || fire) begin
            win_cyc_ff <= 32'h0000_0000;
        end else if (win_cyc_ff != 32'hFFFF_FFFF) begin
            win_cyc_ff <= win_cyc_ff + 32'h0000_0001;
        end
    end

    // Flag checks; one bit of each group stands for the rest of it.
    a_supply_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        wr_supply_a && AVS_WRITEDATA_I[0] && !supply_evt[0] && !proc_rst_ff |=> !supply_a_ff[0])
        else $error("supply flag not cleared");
    a_sys_clear: assert property (@(posedge CORE_CLK_I)
        $rose(RST_B_I) |-> supply_a_ff == dfw_pkg::SUPPLY_RST
        && supply_b_ff == dfw_pkg::SUPPLY_RST && fe_flags_ff == dfw_pkg::FE_RST)
        else $error("flags not cleared by reset");
    a_fe_ov12: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        fe_evt[0] && !proc_rst_ff |=> fe_flags_ff[0])
        else $error("overvoltage flag lost");
    a_fe_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        fe_flags_ff[2] && (!wr_fe || AVS_WRITEDATA_I[2]) && !proc_rst_ff |=> fe_flags_ff[2])
        else $error("front-end flag dropped");
    a_fe_ov3: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        fe_evt[5] && !proc_rst_ff |=> fe_flags_ff[5])
        else $error("third channel flag lost");
    a_fe_out: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        fe_evt[8] && !proc_rst_ff |=> fe_flags_ff[8])
        else $error("stage output flag lost");

    // Steering checks.
    a_cfg_write: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        wr_cfg_a && !proc_rst_ff |=> FE_DIAG_CFG_A_O == $past(AVS_WRITEDATA_I[15:0]))
        else $error("config write lost");
    a_sens_lb: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        wr_sens && !proc_rst_ff |=> SENSOR_LB_O == $past(AVS_WRITEDATA_I[0]))
        else $error("sensor loopback write lost");
    a_poll_split: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        CONV_LB_O |-> !ANALOG_POLL_EN_O && DIGITAL_POLL_EN_O)
        else $error("polling during loopback");
    a_conv_drive: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        !proc_rst_ff |-> CONV_OUT_DRIVE_O)
        else $error("converter output not driven");

    // Watchdog checks; the two timing checks compare against the independent cycle count.
    a_wd_enable: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        wr_wd && AVS_WRITEDATA_I[dfw_pkg::WD_EN_BIT] |=> wd_state_ff == WD_RUN)
        else $error("watchdog not enabled");
    a_late_time: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        late_fire |-> win_cyc_ff == 32'(high_lim) * 32'(TICK_CYCLES))
        else $error("late limit timing");
    a_early_time: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        early_fire |-> win_cyc_ff < 32'(low_lim) * 32'(TICK_CYCLES))
        else $error("early limit timing");
    a_early_reset: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        early_fire |=> PROC_RST_O)
        else $error("early service not reset");
    a_flag_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        flag_clr && !fire |=> !wd_rst_flag_ff)
        else $error("reset flag not cleared");
    a_window_restart: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
        restart |=> ticks_ff == 9'h000 && div_ff == '0)
        else $error("window not restarted");
endmodule

// [dfw_pkg.sv]
// Package with register map, field positions and timing constants of the diagnostics block.
package dfw_pkg;
    // Word byte addresses on the Avalon-MM slave.
    localparam logic [4:0] ADDR_SUPPLY_A = 5'h00;
    localparam logic [4:0] ADDR_SUPPLY_B = 5'h04;
    localparam logic [4:0] ADDR_FE_FLAGS = 5'h08;
    localparam logic [4:0] ADDR_FE_CFG_A = 5'h0C;
    localparam logic [4:0] ADDR_FE_CFG_B = 5'h10;
    localparam logic [4:0] ADDR_SENS_LB = 5'h14;
    localparam logic [4:0] ADDR_CONV_LB = 5'h18;
    localparam logic [4:0] ADDR_WD_CTRL = 5'h1C;
    // Second register window: trigger values.
    localparam logic [5:0] ADDR_WD_HIGH = 6'h20;
    localparam logic [5:0] ADDR_WD_LOW = 6'h24;
    // Field positions.
    localparam int SENS_LB_EN_BIT = 0;
    localparam int CONV_CONNECT_BIT = 0;
    localparam int CONV_AMP_EN_BIT = 1;
    localparam int CONV_LB_EN_BIT = 2;
    localparam int WD_EN_BIT = 0;
    localparam int WD_RST_FLAG_BIT = 1;
    localparam int WD_EARLY_BIT = 2;
    // Front-end flag layout: overvoltage on channel inputs, then stage outputs.
    localparam int FE_OV12_LSB = 0;
    localparam int FE_OV3_LSB = 4;
    localparam int FE_OUT_LSB = 6;
    // Reset values.
    localparam logic [15:0] SUPPLY_RST = 16'h0000;
    localparam logic [8:0] FE_RST = 9'h000;
    localparam logic [7:0] TRIG_RST = 8'hFF;
    // Watchdog tick timing.
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 2;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // Processor reset pulse length in cycles.
    localparam int PROC_RST_CYCLES = 16;
endpackage

// [dfw_diag_test.sv]
// Self-checking testbench of the diagnostics latches, loopback steering and watchdog.
`timescale 1ns/100ps
module dfw_diag_test;
    typedef struct {logic [5:0] a; bit w; logic [31:0] d; logic [31:0] e;} dfw_row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] addr = 5'h00;
    logic hi = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] r;
    logic wait_o;
    logic [15:0] sup = 16'h0000;
    logic [3:0] ov12 = 4'h0;
    logic [1:0] ov3 = 2'h0;
    logic [2:0] ovr = 3'h0;
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic sens_lb, conv_lb, apoll, dpoll, drv, zero, prst;
    logic [7:0] gpio_o;
    logic [7:0] gpio_oe;
    int bad_count = 0;
    int check_count = 0;
    int n;
    int m;
    dfw_row_t rows[13];
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end

    dfw_diag #(.TICK_CYCLES(20), .GPIO_W(8)) u_dfw_diag (
        .CORE_CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_o), .AVS_HIGH_WIN_I(hi),
        .SUPPLY_FAULT_I(sup), .FE_OV12_I(ov12), .FE_OV3_I(ov3), .FE_OUT_OVER_I(ovr),
        .GPIO_OUT_I(8'hA5), .GPIO_OE_I(8'hFF), .FE_DIAG_CFG_A_O(cfg_a),
        .FE_DIAG_CFG_B_O(cfg_b), .SENSOR_LB_O(sens_lb), .CONV_LB_O(conv_lb),
        .ANALOG_POLL_EN_O(apoll), .DIGITAL_POLL_EN_O(dpoll), .CONV_OUT_DRIVE_O(drv),
        .CONV_OUT_ZERO_O(zero), .PROC_RST_O(prst), .GPIO_OUT_O(gpio_o), .GPIO_OE_O(gpio_oe));

    // Free-running 25 MHz core clock.
    always #20 clk = ~clk;

    // The request holds until the rising edge at which waitrequest is sampled low.
    task automatic bus(input logic [5:0] a, input bit w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        hi <= a[5];
        addr <= a[4:0];
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wait_o !== 1'b0 && k < 50) begin
            k++;
            @(posedge clk);
        end
        if (k >= 50) bad_count++;
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Raises some bits of each fault input for four cycles, then drops them again.
    task automatic faults();
        @(posedge clk);
        sup <= 16'h0101;
        ov12 <= 4'h5;
        ov3 <= 2'h2;
        ovr <= 3'h4;
        repeat (4) @(posedge clk);
        sup <= 16'h0000;
        ov12 <= 4'h0;
        ov3 <= 2'h0;
        ovr <= 3'h0;
        repeat (5) @(posedge clk);
    endtask

    task automatic sys_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs far fewer cycles than this.
    initial begin
        #(40 * 20000);
        bad_count++;
        results();
    end

    // Main sequence: table rows first, then loopback, fault and watchdog cases.
    initial begin
        rows = '{'{6'h00, 0, 0, 0}, '{6'h04, 0, 0, 0}, '{6'h08, 0, 0, 0}, '{6'h1C, 0, 0, 0},
            '{6'h20, 0, 0, 32'hFF}, '{6'h24, 0, 0, 0}, '{6'h0C, 1, 32'hA5C3, 0},
            '{6'h0C, 0, 0, 32'hA5C3}, '{6'h10, 1, 32'h3C5A, 0}, '{6'h10, 0, 0, 32'h3C5A},
            '{6'h14, 1, 1, 0}, '{6'h14, 0, 0, 1}, '{6'h28, 0, 0, 0}};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) `CHK(r, rows[i].e)
        end
        `CHK(cfg_a, 16'hA5C3)
        `CHK(cfg_b, 16'h3C5A)
        `CHK(sens_lb, 1'b1)
        // Every combination of the three converter loopback bits.
        for (int i = 0; i < 8; i++) begin
            bus(6'h18, 1, i);
            @(negedge clk);
            `CHK(conv_lb, (i == 7))
            `CHK(apoll, (i != 7))
            `CHK(dpoll, 1'b1)
            `CHK(drv, 1'b1)
        end
        `CHK(gpio_o, 8'hA5)
        `CHK(gpio_oe, 8'hFF)
        `CHK(zero, 1'b0)
        faults();
        bus(6'h00, 0, 0);
        `CHK(r, 32'h1)
        bus(6'h04, 0, 0);
        `CHK(r, 32'h1)
        bus(6'h08, 0, 0);
        `CHK(r, 32'h125)
        bus(6'h00, 1, 0);
        bus(6'h00, 0, 0);
        `CHK(r, 32'h1)
        bus(6'h00, 1, 1);
        bus(6'h00, 0, 0);
        `CHK(r, 32'h0)
        bus(6'h04, 1, 32'h00010001);
        bus(6'h04, 0, 0);
        `CHK(r, 32'h0)
        bus(6'h08, 1, 32'h1FF);
        bus(6'h08, 0, 0);
        `CHK(r, 32'h125)
        bus(6'h08, 1, 32'h1FE);
        bus(6'h08, 0, 0);
        `CHK(r, 32'h124)
        faults();
        sys_reset();
        bus(6'h00, 0, 0);
        `CHK(r, 32'h0)
        bus(6'h08, 0, 0);
        `CHK(r, 32'h0)
        // Watchdog: late fire, early service, then one service inside the window.
        bus(6'h0C, 1, 32'h1234);
        bus(6'h20, 1, 5);
        bus(6'h24, 1, 1);
        repeat (260) @(posedge clk);
        bus(6'h1C, 1, 1);
        n = 0;
        while (prst !== 1'b1 && n < 300) begin
            n++;
            @(negedge clk);
        end
        `CHK((n >= 120 && n <= 123), 1'b1)
        `CHK(gpio_oe, 8'h00)
        `CHK(zero, 1'b1)
        `CHK(gpio_o, 8'h00)
        `CHK(drv, 1'b0)
        m = 0;
        while (prst === 1'b1 && m < 40) begin
            m++;
            @(negedge clk);
        end
        `CHK(m, 16)
        bus(6'h1C, 0, 0);
        `CHK(r[2:0], 3'h3)
        bus(6'h0C, 1, 32'h1234);
        bus(6'h20, 1, 5);
        n = 0;
        while (prst !== 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        `CHK(prst, 1'b1)
        repeat (17) @(negedge clk);
        bus(6'h0C, 0, 0);
        `CHK(r, 32'h0)
        bus(6'h1C, 0, 0);
        `CHK(r[2:0], 3'h7)
        bus(6'h1C, 1, 2);
        bus(6'h1C, 0, 0);
        `CHK(r[1:0], 2'h1)
        repeat (30) @(posedge clk);
        bus(6'h20, 1, 5);
        n = 0;
        repeat (90) begin
            @(negedge clk);
            if (prst !== 1'b0) n++;
        end
        `CHK(n, 0)
        results();
    end
endmodule
